// ==== src/floppy_cmd_pkg.sv ====
// shared constants for the floppy positioning command decoder
package floppy_cmd_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int STEP_UNIT_NS = 1000;
	localparam int STEP_UNIT_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECAL_MAX_STEPS = 80;
	localparam logic [4:0] STEP_RATE_SPAN = 5'h10;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_MAIN_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

	// ------------------------------------------------------------
	// opcodes and opcode masks
	// ------------------------------------------------------------
	localparam logic [7:0] OP_RECALIBRATE = 8'h07;
	localparam logic [7:0] OP_SEEK = 8'h0f;
	localparam logic [7:0] OP_RELSEEK_MASK = 8'hbf;
	localparam logic [7:0] OP_RELSEEK = 8'h8f;
	localparam logic [7:0] OP_DUMP = 8'h0e;
	localparam logic [7:0] OP_LOCK_MASK = 8'h7f;
	localparam logic [7:0] OP_LOCK = 8'h14;
	localparam logic [7:0] OP_VERSION = 8'h10;
	localparam logic [7:0] OP_SENSE_INT = 8'h08;
	localparam logic [7:0] OP_SENSE_DRIVE = 8'h04;
	localparam logic [7:0] OP_SPECIFY = 8'h03;
	localparam logic [7:0] OP_PERPENDICULAR = 8'h12;

	// ------------------------------------------------------------
	// field positions and result values
	// ------------------------------------------------------------
	localparam int BIT_LOCK_CMD = 7;
	localparam int BIT_LOCK_RESULT = 4;
	localparam int BIT_REL_DIR = 6;
	localparam int BIT_HEAD = 2;
	localparam int BIT_OW = 7;
	localparam logic [7:0] VERSION_RESULT = 8'h90;
	localparam logic [7:0] INVALID_STATUS = 8'h80;
	localparam logic [7:0] SEEK_END_STATUS = 8'h20;
	localparam logic [7:0] DRIVE_READY_TWO_SIDE = 8'h28;
	localparam int BIT_ST3_WP = 6;
	localparam int BIT_ST3_TRACK0 = 4;
	localparam int RESULT_DEPTH = 10;
	localparam logic [3:0] DUMP_LEN = 4'ha;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] SRT_RESET = 4'h0;
	localparam logic [3:0] HUT_RESET = 4'h0;
	localparam logic [6:0] HLT_RESET = 7'h00;
	localparam logic [7:0] EOT_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] PRECOMP_START_TRACK_RESET = 8'h00;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// interrupt status bits
	localparam int IRQ_SEEK_DONE = 0;
	localparam int IRQ_INVALID = 1;
	localparam int IRQ_RESULT = 2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		PH_COMMAND = 2'b00,
		PH_PARAM = 2'b01,
		PH_EXEC = 2'b10,
		PH_RESULT = 2'b11
	} phase_type;

	typedef enum logic {
		POS_IDLE = 1'b0,
		POS_MOVE = 1'b1
	} pos_state_type;

endpackage

// ==== src/positioner_if.sv ====
// request and state signals between the decoder and the head positioner
interface positioner_if;
	logic start;
	logic recal;
	logic [1:0] drive;
	logic [7:0] target;
	logic [3:0] step_rate;
	logic busy;
	logic done;
	logic [3:0][7:0] present_cylinder;
	modport decoder (output start, recal, drive, target, step_rate, input busy, done, present_cylinder);
	modport positioner (input start, recal, drive, target, step_rate, output busy, done, present_cylinder);
endinterface

// ==== src/head_positioner.sv ====
// steps the selected head to a target cylinder or back to track zero
module head_positioner #(
	parameter int step_unit_cycles = floppy_cmd_pkg::STEP_UNIT_CYCLES,
	parameter int recal_max_steps = floppy_cmd_pkg::RECAL_MAX_STEPS
) (
	input wire logic aclk,
	input wire logic aresetn,
	positioner_if.positioner pos,
	input wire logic [3:0] track0,
	output logic step_pulse,
	output logic step_direction
);

	floppy_cmd_pkg::pos_state_type state;
	logic [15:0] unit_count;
	logic unit_tick;
	logic [4:0] interval_count;
	logic [4:0] interval;
	logic [1:0] drive;
	logic [7:0] target;
	logic recal;
	logic [7:0] steps;
	logic [7:0] here;
	logic arrived;
	logic step_due;

	assign interval = floppy_cmd_pkg::STEP_RATE_SPAN - {1'b0, pos.step_rate};
	assign unit_tick = (unit_count == 16'(step_unit_cycles - 1));
	assign step_due = (state == floppy_cmd_pkg::POS_MOVE) && unit_tick
		&& (interval_count >= interval - 5'h01);
	assign here = pos.present_cylinder[drive];
	// recalibrate gives up after a fixed number of steps so a dead sensor cannot hang it
	assign arrived = recal ? (track0[drive] || steps == 8'(recal_max_steps)) : (here == target);
	assign pos.busy = (state == floppy_cmd_pkg::POS_MOVE);

	// ------------------------------------------------------------
	// step timing
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state == floppy_cmd_pkg::POS_IDLE || unit_tick)
			unit_count <= 16'h0000;
		else
			unit_count <= unit_count + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state == floppy_cmd_pkg::POS_IDLE || step_due)
			interval_count <= 5'h00;
		else if (unit_tick)
			interval_count <= interval_count + 5'h01;
	end

	// ------------------------------------------------------------
	// motion
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= floppy_cmd_pkg::POS_IDLE;
			drive <= 2'h0;
			target <= 8'h00;
			recal <= 1'b0;
			steps <= 8'h00;
			pos.present_cylinder <= '0;
			pos.done <= 1'b0;
			step_pulse <= 1'b0;
			step_direction <= 1'b0;
		end
		else
		begin
			pos.done <= 1'b0;
			step_pulse <= 1'b0;
			unique case (state)
				floppy_cmd_pkg::POS_IDLE:
				begin
					if (pos.start)
					begin
						drive <= pos.drive;
						target <= pos.target;
						recal <= pos.recal;
						steps <= 8'h00;
						state <= floppy_cmd_pkg::POS_MOVE;
					end
				end
				floppy_cmd_pkg::POS_MOVE:
				begin
					if (step_due)
					begin
						if (arrived)
						begin
							if (recal)
								pos.present_cylinder[drive] <= 8'h00;
							pos.done <= 1'b1;
							state <= floppy_cmd_pkg::POS_IDLE;
						end
						else if (recal)
						begin
							step_direction <= 1'b0;
							step_pulse <= 1'b1;
							steps <= steps + 8'h01;
						end
						else
						begin
							step_direction <= (target > here);
							step_pulse <= 1'b1;
							pos.present_cylinder[drive] <= (target > here) ? here + 8'h01 : here - 8'h01;
						end
					end
				end
			endcase
		end
	end

endmodule // head_positioner

// ==== src/floppy_positioning_command_decoder.sv ====
// positioning and status command decoder for a floppy disk controller, axi4-lite registers

// How it works
// - recalibrate retracts chosen drive to cylinder zero
// - seek moves selected head to target cylinder
// - relative seek steps head in or out
// - dump returns ten bytes of internal state
// - sense interrupt returns status and present cylinder after a seek end, otherwise single byte 80h
// - sense drive status returns one status byte
// - unknown opcode gives single byte 80h
module floppy_positioning_command_decoder #(
	parameter int step_unit_cycles = floppy_cmd_pkg::STEP_UNIT_CYCLES,
	parameter int recal_max_steps = floppy_cmd_pkg::RECAL_MAX_STEPS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] track0_pin,
	input wire logic [3:0] write_protect_pin,
	output logic drive_select_high,
	output logic drive_select_low,
	output logic head_side_select,
	output logic step_pulse,
	output logic step_direction,
	output logic irq
);

	positioner_if pos ();

	floppy_cmd_pkg::phase_type phase;
	logic aw_held;
	logic w_held;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic do_read;
	logic data_write;
	logic data_pop;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [7:0] cmd_byte;
	logic [7:0] cur_op;
	logic [7:0] opcode;
	logic [1:0] param_idx;
	logic [7:0] head_drive;
	logic last_param;
	logic exec_now;
	logic [7:0] results [floppy_cmd_pkg::RESULT_DEPTH];
	logic [3:0] result_len;
	logic [3:0] result_idx;
	logic seek_req;
	logic seek_recal;
	logic [7:0] seek_target;
	logic [1:0] seek_drive;
	logic seek_pending;
	logic [7:0] seek_status;
	logic [1:0] done_drive;
	logic [3:0] step_rate_time;
	logic [3:0] head_unload_time;
	logic [6:0] head_load_time;
	logic no_dma;
	logic lock;
	logic [7:0] perp;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [2:0] irq_events;
	logic [3:0] track0_meta;
	logic [3:0] track0_sync;
	logic [3:0] wp_meta;
	logic [3:0] wp_sync;

	// ------------------------------------------------------------
	// opcode helpers
	// ------------------------------------------------------------
	function automatic logic is_relseek(input logic [7:0] op);
		return (op & floppy_cmd_pkg::OP_RELSEEK_MASK) == floppy_cmd_pkg::OP_RELSEEK;
	endfunction

	function automatic logic is_lock(input logic [7:0] op);
		return (op & floppy_cmd_pkg::OP_LOCK_MASK) == floppy_cmd_pkg::OP_LOCK;
	endfunction

	// number of parameter bytes after the opcode
	function automatic logic [1:0] param_count(input logic [7:0] op);
		if (op == floppy_cmd_pkg::OP_SEEK || is_relseek(op) || op == floppy_cmd_pkg::OP_SPECIFY)
			return 2'h2;
		else if (op == floppy_cmd_pkg::OP_RECALIBRATE || op == floppy_cmd_pkg::OP_SENSE_DRIVE
			|| op == floppy_cmd_pkg::OP_PERPENDICULAR)
			return 2'h1;
		else
			return 2'h0;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		track0_meta <= track0_pin;
		track0_sync <= track0_meta;
		wp_meta <= write_protect_pin;
		wp_sync <= wp_meta;
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= floppy_cmd_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			unique case (awaddr_q)
				floppy_cmd_pkg::ADDR_DATA, floppy_cmd_pkg::ADDR_MAIN_STATUS,
				floppy_cmd_pkg::ADDR_IRQ_STATUS, floppy_cmd_pkg::ADDR_IRQ_MASK:
					s_axi_bresp <= floppy_cmd_pkg::RESP_OKAY;
				default:
					s_axi_bresp <= floppy_cmd_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_comb
	begin
		next_rdata = 32'h00000000;
		next_rresp = floppy_cmd_pkg::RESP_OKAY;
		unique case (s_axi_araddr)
			floppy_cmd_pkg::ADDR_DATA:
				if (phase == floppy_cmd_pkg::PH_RESULT)
					next_rdata = {24'h000000, results[result_idx]};
			floppy_cmd_pkg::ADDR_MAIN_STATUS:
				next_rdata = {20'h00000, result_len - result_idx, 4'h0, seek_pending,
					pos.busy, phase};
			floppy_cmd_pkg::ADDR_IRQ_STATUS:
				next_rdata = {29'h0, irq_status};
			floppy_cmd_pkg::ADDR_IRQ_MASK:
				next_rdata = {29'h0, irq_mask};
			default:
				next_rresp = floppy_cmd_pkg::RESP_SLVERR;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= floppy_cmd_pkg::RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// command sequencing
	// ------------------------------------------------------------
	// writes outside the command and parameter phases are dropped rather than queued
	assign data_write = do_write && awaddr_q == floppy_cmd_pkg::ADDR_DATA && wstrb_q[0]
		&& (phase == floppy_cmd_pkg::PH_COMMAND || phase == floppy_cmd_pkg::PH_PARAM);
	assign data_pop = do_read && s_axi_araddr == floppy_cmd_pkg::ADDR_DATA
		&& phase == floppy_cmd_pkg::PH_RESULT;
	assign cmd_byte = wdata_q[7:0];
	assign cur_op = (phase == floppy_cmd_pkg::PH_COMMAND) ? cmd_byte : opcode;
	assign last_param = (phase == floppy_cmd_pkg::PH_PARAM)
		&& (param_idx == param_count(opcode) - 2'h1);
	assign exec_now = data_write && (last_param
		|| (phase == floppy_cmd_pkg::PH_COMMAND && param_count(cmd_byte) == 2'h0));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase <= floppy_cmd_pkg::PH_COMMAND;
			opcode <= 8'h00;
			param_idx <= 2'h0;
			head_drive <= 8'h00;
			result_len <= 4'h0;
			result_idx <= 4'h0;
			seek_req <= 1'b0;
			seek_recal <= 1'b0;
			seek_target <= 8'h00;
			seek_drive <= 2'h0;
			for (int i = 0; i < floppy_cmd_pkg::RESULT_DEPTH; i++)
				results[i] <= 8'h00;
		end
		else
		begin
			unique case (phase)
				floppy_cmd_pkg::PH_COMMAND:
				begin
					if (data_write)
					begin
						opcode <= cmd_byte;
						param_idx <= 2'h0;
						result_idx <= 4'h0;
						if (param_count(cmd_byte) != 2'h0)
							phase <= floppy_cmd_pkg::PH_PARAM;
						else
						begin
							phase <= floppy_cmd_pkg::PH_RESULT;
							result_len <= 4'h1;
							if (cmd_byte == floppy_cmd_pkg::OP_DUMP)
							begin
								for (int d = 0; d < 4; d++)
									results[d] <= pos.present_cylinder[d];
								results[4] <= {step_rate_time, head_unload_time};
								results[5] <= {head_load_time, no_dma};
								results[6] <= floppy_cmd_pkg::EOT_RESET;
								results[7] <= {lock, perp[6:0]};
								results[8] <= floppy_cmd_pkg::CONFIG_RESET;
								results[9] <= floppy_cmd_pkg::PRECOMP_START_TRACK_RESET;
								result_len <= floppy_cmd_pkg::DUMP_LEN;
							end
							else if (is_lock(cmd_byte))
								results[0] <= {3'h0, cmd_byte[floppy_cmd_pkg::BIT_LOCK_CMD],
									4'h0};
							else if (cmd_byte == floppy_cmd_pkg::OP_VERSION)
								results[0] <= floppy_cmd_pkg::VERSION_RESULT;
							else if (cmd_byte == floppy_cmd_pkg::OP_SENSE_INT && seek_pending)
							begin
								results[0] <= seek_status;
								results[1] <= pos.present_cylinder[done_drive];
								result_len <= 4'h2;
							end
							else
								results[0] <= floppy_cmd_pkg::INVALID_STATUS;
						end
					end
				end
				floppy_cmd_pkg::PH_PARAM:
				begin
					if (data_write)
					begin
						param_idx <= param_idx + 2'h1;
						if (param_idx == 2'h0)
							head_drive <= cmd_byte;
						if (last_param)
						begin
							phase <= floppy_cmd_pkg::PH_COMMAND;
							seek_drive <= (param_idx == 2'h0) ? cmd_byte[1:0] : head_drive[1:0];
							if (opcode == floppy_cmd_pkg::OP_RECALIBRATE)
							begin
								seek_recal <= 1'b1;
								seek_target <= 8'h00;
								phase <= floppy_cmd_pkg::PH_EXEC;
							end
							else if (opcode == floppy_cmd_pkg::OP_SEEK)
							begin
								seek_recal <= 1'b0;
								seek_target <= cmd_byte;
								phase <= floppy_cmd_pkg::PH_EXEC;
							end
							else if (is_relseek(opcode))
							begin
								seek_recal <= 1'b0;
								// the count is clamped at the ends of the cylinder range
								if (opcode[floppy_cmd_pkg::BIT_REL_DIR])
									seek_target <= (pos.present_cylinder[head_drive[1:0]] > 8'hff - cmd_byte)
										? 8'hff : pos.present_cylinder[head_drive[1:0]] + cmd_byte;
								else
									seek_target <= (pos.present_cylinder[head_drive[1:0]] < cmd_byte)
										? 8'h00 : pos.present_cylinder[head_drive[1:0]] - cmd_byte;
								phase <= floppy_cmd_pkg::PH_EXEC;
							end
							else if (opcode == floppy_cmd_pkg::OP_SENSE_DRIVE)
							begin
								results[0] <= floppy_cmd_pkg::DRIVE_READY_TWO_SIDE
									| {1'b0, wp_sync[cmd_byte[1:0]], 6'h00}
									| {3'h0, track0_sync[cmd_byte[1:0]], 4'h0}
									| {5'h00, cmd_byte[2:0]};
								result_len <= 4'h1;
								phase <= floppy_cmd_pkg::PH_RESULT;
							end
						end
					end
				end
				floppy_cmd_pkg::PH_EXEC:
				begin
					// a new seek waits until the head in motion has settled
					if (!pos.busy && !seek_req)
						seek_req <= 1'b1;
					else if (seek_req)
					begin
						seek_req <= 1'b0;
						phase <= floppy_cmd_pkg::PH_COMMAND;
					end
				end
				floppy_cmd_pkg::PH_RESULT:
				begin
					if (data_pop)
					begin
						result_idx <= result_idx + 4'h1;
						if (result_idx == result_len - 4'h1)
							phase <= floppy_cmd_pkg::PH_COMMAND;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// positioner requests and seek end reporting
	// ------------------------------------------------------------
	assign pos.start = seek_req;
	assign pos.recal = seek_recal;
	assign pos.drive = seek_drive;
	assign pos.target = seek_target;
	assign pos.step_rate = step_rate_time;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			seek_pending <= 1'b0;
			seek_status <= 8'h00;
			done_drive <= 2'h0;
			drive_select_high <= 1'b0;
			drive_select_low <= 1'b0;
			head_side_select <= 1'b0;
		end
		else
		begin
			if (seek_req)
			begin
				drive_select_high <= seek_drive[1];
				drive_select_low <= seek_drive[0];
				head_side_select <= head_drive[floppy_cmd_pkg::BIT_HEAD] && !seek_recal;
			end
			// a finishing seek wins over a sense interrupt taken in the same cycle
			if (pos.done)
			begin
				seek_pending <= 1'b1;
				done_drive <= {drive_select_high, drive_select_low};
				seek_status <= floppy_cmd_pkg::SEEK_END_STATUS
					| {5'h00, head_side_select, drive_select_high, drive_select_low};
			end
			else if (exec_now && cur_op == floppy_cmd_pkg::OP_SENSE_INT)
				seek_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// configuration held by specify, perpendicular and lock
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			step_rate_time <= floppy_cmd_pkg::SRT_RESET;
			head_unload_time <= floppy_cmd_pkg::HUT_RESET;
			head_load_time <= floppy_cmd_pkg::HLT_RESET;
			no_dma <= 1'b0;
			lock <= 1'b0;
			perp <= 8'h00;
		end
		else if (data_write && phase == floppy_cmd_pkg::PH_PARAM)
		begin
			if (opcode == floppy_cmd_pkg::OP_SPECIFY && param_idx == 2'h0)
			begin
				step_rate_time <= cmd_byte[7:4];
				head_unload_time <= cmd_byte[3:0];
			end
			else if (opcode == floppy_cmd_pkg::OP_SPECIFY)
			begin
				head_load_time <= cmd_byte[7:1];
				no_dma <= cmd_byte[0];
			end
			else if (opcode == floppy_cmd_pkg::OP_PERPENDICULAR)
			begin
				// drive bits change only when the overwrite bit is set
				if (cmd_byte[floppy_cmd_pkg::BIT_OW])
					perp[5:2] <= cmd_byte[5:2];
				perp[1:0] <= cmd_byte[1:0];
			end
		end
		else if (exec_now && phase == floppy_cmd_pkg::PH_COMMAND && is_lock(cmd_byte))
			lock <= cmd_byte[floppy_cmd_pkg::BIT_LOCK_CMD];
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	assign irq_events[floppy_cmd_pkg::IRQ_SEEK_DONE] = pos.done;
	assign irq_events[floppy_cmd_pkg::IRQ_INVALID] = exec_now
		&& phase == floppy_cmd_pkg::PH_COMMAND && !is_lock(cmd_byte)
		&& cmd_byte != floppy_cmd_pkg::OP_DUMP && cmd_byte != floppy_cmd_pkg::OP_VERSION
		&& cmd_byte != floppy_cmd_pkg::OP_SENSE_INT;
	assign irq_events[floppy_cmd_pkg::IRQ_RESULT] = exec_now
		&& (phase == floppy_cmd_pkg::PH_COMMAND || opcode == floppy_cmd_pkg::OP_SENSE_DRIVE);
	assign irq = |(irq_status & irq_mask);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_status <= 3'h0;
		else if (do_read && s_axi_araddr == floppy_cmd_pkg::ADDR_IRQ_STATUS)
			irq_status <= irq_events;
		else
			irq_status <= irq_status | irq_events;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_mask <= floppy_cmd_pkg::IRQ_MASK_RESET;
		else if (do_write && awaddr_q == floppy_cmd_pkg::ADDR_IRQ_MASK && wstrb_q[0])
			irq_mask <= wdata_q[2:0];
	end

	// ------------------------------------------------------------
	// head positioner
	// ------------------------------------------------------------
	head_positioner #(
		.step_unit_cycles(step_unit_cycles),
		.recal_max_steps(recal_max_steps)
	) positioner (
		.aclk(aclk),
		.aresetn(aresetn),
		.pos(pos),
		.track0(track0_sync),
		.step_pulse(step_pulse),
		.step_direction(step_direction)
	);

endmodule // floppy_positioning_command_decoder

// ==== test/dec_chk.sv ====
// port assertions for the command decoder
module dec_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic drive_select_high,
	input wire logic drive_select_low,
	input wire logic step_pulse,
	input wire logic step_direction
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_step_single:
		assert property (step_pulse |=> !step_pulse) else $error("step pulse too long");
	a_dir_with_step:
		assert property ($changed(step_direction) |-> step_pulse) else $error("direction moved");
	// selection settles at start, well ahead of the first step
	a_sel_steady:
		assert property (step_pulse |-> $stable({drive_select_high, drive_select_low}))
		else $error("select moved at step");
	a_write_answer:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("no write response");
	a_b_drop:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_r_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	a_r_drop:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	a_ar_block:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not blocked");
endmodule // dec_chk

bind floppy_positioning_command_decoder dec_chk u_chk (.*);

// ==== test/disk_drive_model.sv ====
// drive mechanics: cylinder per drive moved by step pulses, track-zero sensors
module disk_drive_model (
	input wire logic aclk,
	input wire logic step_pulse,
	input wire logic step_direction,
	input wire logic drive_select_high,
	input wire logic drive_select_low,
	output logic [3:0] track0_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cyl [4] = '{default: 8'h00};
	logic [1:0] sel;
	assign sel = {drive_select_high, drive_select_low};
	// the carriage stops hard at cylinder zero
	always @(posedge aclk)
		if (step_pulse) cyl[sel] <= step_direction ? cyl[sel] + 8'h01 : cyl[sel] - (cyl[sel] != 8'h00);
	always_comb
		foreach (track0_pin[i]) track0_pin[i] = (cyl[i] == 8'h00);
endmodule // disk_drive_model

// ==== test/floppy_positioning_command_decoder_bench.sv ====
// self-checking bench for the command decoder over axi4-lite
module floppy_positioning_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, write_protect_pin = 4'h2, track0_pin;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic drive_select_high, drive_select_low, head_side_select, step_pulse, step_direction, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] dmp [10] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'ha5, 8'h46, 8'h00, 8'h84, 8'h00, 8'h00};
	int n_errors = 0, samples_checked = 0;

	floppy_positioning_command_decoder #(.step_unit_cycles(2), .recal_max_steps(4)) DUT (.*);
	disk_drive_model drive (.*);

	initial forever #2 aclk = ~aclk;

	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ga, gw;
		ga = 1'h0;
		gw = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(ga && gw))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			ga = ga | (s_axi_awvalid & s_axi_awready);
			gw = gw | (s_axi_wvalid & s_axi_wready);
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task cmd(input int n, input logic [7:0] a, input logic [7:0] b = 8'h00, c = 8'h00);
		wr(8'h00, {24'h0, a});
		if (n > 1) wr(8'h00, {24'h0, b});
		if (n > 2) wr(8'h00, {24'h0, c});
	endtask

	task rc(input logic [7:0] e);
		rd(8'h00);
		chk("result", d, {24'h0, e});
	endtask

	// polls for seek end, then collects the sense interrupt pair
	task sk(input logic [7:0] s, input logic [7:0] p);
		d = 32'h0;
		for (int i = 0; i < 400 && !d[0]; i++) rd(8'h08);
		cmd(1, 8'h08);
		rc(s);
		rc(p);
	endtask

	initial
	begin
		repeat (50000) @(posedge aclk);
		n_errors++;
		report_and_stop;
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		wr(8'h0c, 32'h2);
		cmd(1, 8'h01);
		@(posedge aclk);
		#1 chk("irq", {31'h0, irq}, 32'h1);
		rd(8'h08);
		chk("irq_status", d & 32'h2, 32'h2);
		rc(8'h80);
		@(posedge aclk);
		#1 chk("irq", {31'h0, irq}, 32'h0);
		foreach (dmp[i]) if (i < 3) begin cmd(1, 8'h13 + 8'h76 * i[7:0]); rc(8'h80); end
		rd(8'h10);
		chk("resp", {30'h0, r}, 32'h2);
		wr(8'h10, 32'h0);
		chk("bresp", {30'h0, r}, 32'h2);
		cmd(1, 8'h10);
		rc(8'h90);
		cmd(1, 8'h14);
		rc(8'h00);
		cmd(1, 8'h94);
		rc(8'h10);
		cmd(3, 8'h03, 8'ha5, 8'h46);
		cmd(3, 8'h0f, 8'h05, 8'h03);
		sk(8'h25, 8'h03);
		chk("select", {29'h0, drive_select_high, drive_select_low, head_side_select}, 32'h3);
		cmd(3, 8'hcf, 8'h05, 8'h02);
		sk(8'h25, 8'h05);
		cmd(3, 8'h8f, 8'h05, 8'h01);
		sk(8'h25, 8'h04);
		cmd(1, 8'h08);
		rc(8'h80);
		cmd(2, 8'h12, 8'h84);
		cmd(1, 8'h0e);
		rd(8'h04);
		chk("main_status", d, 32'h00000a03);
		foreach (dmp[i]) rc(dmp[i]);
		cmd(2, 8'h07, 8'h01);
		sk(8'h21, 8'h00);
		cmd(2, 8'h04, 8'h05);
		rc(8'h7d);
		report_and_stop;
	end
endmodule // floppy_positioning_command_decoder_bench
